// ===== hdl/vrdc_pkg.sv
package vrdc_pkg;
    localparam logic [7:0] ADDR0_HIGH_OFF = 8'h18;
    localparam logic [7:0] ADDR0_MID_OFF = 8'h19;
    localparam logic [7:0] ADDR0_LOW_OFF = 8'h1A;
    localparam logic [7:0] ADDR1_HIGH_OFF = 8'h1B;
    localparam logic [7:0] ADDR1_MID_OFF = 8'h1C;
    localparam logic [7:0] ADDR1_LOW_OFF = 8'h1D;
    localparam logic [7:0] VOICE_CONTROL_OFF = 8'h26;
    localparam logic [7:0] AUDIO_LOW_OFF = 8'h27;
    localparam logic [7:0] AUDIO_HIGH_OFF = 8'h28;
    localparam logic [7:0] VOLUME_OFF = 8'h29;
    localparam logic [7:0] ROM_BYTE_OFF = 8'h2A;
    localparam int DAC_EN_BIT = 1;
    localparam int ROM_EN_BIT = 2;
    localparam int SEL_BIT = 4;
    localparam int SLOW_START_BIT = 7;
    localparam logic [7:0] VOICE_CONTROL_MASK = 8'h96;
    localparam logic [7:0] VOICE_CONTROL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] ADDR_HIGH_MASK = 4'hF;
    localparam int CLK_MHZ = 25;
    localparam int FETCH_NS = 4000;
    localparam int FETCH_CYC = (FETCH_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] FETCH_CYC_W = 8'(FETCH_CYC);

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vrdc_bus_t;

    typedef struct packed {
        logic req;
        logic [19:0] addr;
    } vrdc_rom_req_t;

    typedef struct packed {
        logic en;
        logic [11:0] sample;
        logic [2:0] volume;
    } vrdc_dac_t;
endpackage

// ===== hdl/vrdc_top.sv
// Functional notes
// - Sample is high byte plus low upper nibble
// - Low audio lower nibble reads zero
// - Eight volume levels from upper nibble
// - Volume lower nibble reads zero
// - Control bit 1 enables DAC
// - DAC disabled means sample is invalid
// - Halt never changes DAC enable
// - Control bit 2 enables voice ROM
// - ROM disabled means no access, no data
// - Control bit 4 selects address counter
// - Control bit 7 selects crystal start
// - Counter address is high, mid, low bytes
// - Fetch needs at least four microseconds
// - Fetched byte readable at 2AH
`timescale 1ns/1ps
`default_nettype none
module vrdc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire vrdc_pkg::vrdc_bus_t bus_i,
    input wire logic halt_i,
    input wire logic [7:0] rom_data_i,
    output logic [7:0] rdata_o,
    output vrdc_pkg::vrdc_rom_req_t rom_o,
    output vrdc_pkg::vrdc_dac_t dac_o,
    output logic xtal_slow_start_o,
    output logic rom_busy_o
);
    import vrdc_pkg::*;

    typedef enum logic [1:0] {VRDC_IDLE, VRDC_WAIT} vrdc_state_t;

    logic [7:0] ctrl_r, ctrl_nxt;
    logic [3:0] alow_r, alow_nxt;
    logic [7:0] ahigh_r, ahigh_nxt;
    logic [2:0] vol_r, vol_nxt;
    logic [7:0] romb_r, romb_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [7:0] abyte_r [0:5];
    logic [7:0] abyte_nxt [0:5];
    logic [5:0] hit;
    vrdc_state_t st_r, st_nxt;
    vrdc_rom_req_t rom_r, rom_nxt;
    vrdc_dac_t dac_r, dac_nxt;
    logic [19:0] sel_addr;
    logic addr_wr;
    logic sel_c;
    logic xtal_nxt, busy_nxt;
    logic [7:0] busy_len_r, busy_len_nxt;

    assign sel_c = ctrl_nxt[SEL_BIT];

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_addr
            assign hit[g] = bus_i.we && (bus_i.addr == ADDR0_HIGH_OFF + 8'(g));
            always_comb begin
                abyte_nxt[g] = hit[g] ? bus_i.wdata : abyte_r[g];
                if (g == 0 || g == 3) begin
                    abyte_nxt[g][7:4] = 4'h0;
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    abyte_r[g] <= DATA_RST;
                end else begin
                    abyte_r[g] <= abyte_nxt[g];
                end
            end
        end
    endgenerate

    // Address from the counter chosen by the control select bit
    always_comb begin
        if (sel_c) begin
            sel_addr = {abyte_nxt[3][3:0], abyte_nxt[4], abyte_nxt[5]};
        end else begin
            sel_addr = {abyte_nxt[0][3:0], abyte_nxt[1], abyte_nxt[2]};
        end
    end
    assign addr_wr = sel_c ? |hit[5:3] : |hit[2:0];

    always_comb begin
        ctrl_nxt = ctrl_r;
        alow_nxt = alow_r;
        ahigh_nxt = ahigh_r;
        vol_nxt = vol_r;
        if (bus_i.we) begin
            if (bus_i.addr == VOICE_CONTROL_OFF) begin
                // Halt does not enter here; only writes move bits
                ctrl_nxt = bus_i.wdata & VOICE_CONTROL_MASK;
            end else if (bus_i.addr == AUDIO_LOW_OFF) begin
                alow_nxt = bus_i.wdata[7:4];
            end else if (bus_i.addr == AUDIO_HIGH_OFF) begin
                ahigh_nxt = bus_i.wdata;
            end else if (bus_i.addr == VOLUME_OFF) begin
                vol_nxt = bus_i.wdata[6:4];
            end
        end
    end

    // Fetch sequencer
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        romb_nxt = romb_r;
        rom_nxt.addr = sel_addr;
        rom_nxt.req = 1'b0;
        if (!ctrl_nxt[ROM_EN_BIT]) begin
            st_nxt = VRDC_IDLE;
            cnt_nxt = 8'h00;
        end else if (addr_wr || (bus_i.we && bus_i.addr == VOICE_CONTROL_OFF
                && (ctrl_nxt ^ ctrl_r) != 8'h00)) begin
            st_nxt = VRDC_WAIT;
            cnt_nxt = FETCH_CYC_W;
            rom_nxt.req = 1'b1;
        end else begin
            case (st_r)
                VRDC_WAIT: begin
                    rom_nxt.req = 1'b1;
                    if (cnt_r == 8'h01) begin
                        romb_nxt = rom_data_i;
                        st_nxt = VRDC_IDLE;
                        rom_nxt.req = 1'b0;
                    end
                    cnt_nxt = cnt_r - 8'h01;
                end
                default: begin
                    cnt_nxt = 8'h00;
                end
            endcase
        end
    end

    always_comb begin
        dac_nxt.en = ctrl_nxt[DAC_EN_BIT];
        // Disabled DAC is fed silence, not the stale sample
        dac_nxt.sample = ctrl_nxt[DAC_EN_BIT] ? {ahigh_nxt, alow_nxt}
            : 12'h000;
        dac_nxt.volume = vol_nxt;
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (bus_i.re) begin
            if (bus_i.addr == VOICE_CONTROL_OFF) begin
                rdata_nxt = ctrl_r;
            end else if (bus_i.addr == AUDIO_LOW_OFF) begin
                rdata_nxt = {alow_r, 4'h0};
            end else if (bus_i.addr == AUDIO_HIGH_OFF) begin
                rdata_nxt = ahigh_r;
            end else if (bus_i.addr == VOLUME_OFF) begin
                rdata_nxt = {1'b0, vol_r, 4'h0};
            end else if (bus_i.addr == ROM_BYTE_OFF) begin
                rdata_nxt = ctrl_r[ROM_EN_BIT] ? romb_r : 8'h00;
            end else if (bus_i.addr >= ADDR0_HIGH_OFF
                    && bus_i.addr <= ADDR1_LOW_OFF) begin
                rdata_nxt = abyte_r[3'(bus_i.addr - ADDR0_HIGH_OFF)];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= VOICE_CONTROL_RST;
            alow_r <= 4'h0;
            ahigh_r <= DATA_RST;
            vol_r <= 3'h0;
            romb_r <= DATA_RST;
            rdata_r <= DATA_RST;
            cnt_r <= 8'h00;
            st_r <= VRDC_IDLE;
            rom_r <= '0;
            dac_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            alow_r <= alow_nxt;
            ahigh_r <= ahigh_nxt;
            vol_r <= vol_nxt;
            romb_r <= romb_nxt;
            rdata_r <= rdata_nxt;
            cnt_r <= cnt_nxt;
            st_r <= st_nxt;
            rom_r <= rom_nxt;
            dac_r <= dac_nxt;
        end
    end

    always_comb begin
        xtal_nxt = ctrl_nxt[SLOW_START_BIT];
        busy_nxt = (st_nxt == VRDC_WAIT);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xtal_slow_start_o <= 1'b0;
            rom_busy_o <= 1'b0;
        end else begin
            xtal_slow_start_o <= xtal_nxt;
            rom_busy_o <= busy_nxt;
        end
    end

    // Length of the running fetch, saturating; only the checks read it
    always_comb begin
        busy_len_nxt = 8'h00;
        if (rom_busy_o && busy_len_r != 8'hFF) begin
            busy_len_nxt = busy_len_r + 8'h01;
        end else if (rom_busy_o) begin
            busy_len_nxt = busy_len_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_len_r <= 8'h00;
        end else begin
            busy_len_r <= busy_len_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign rom_o = rom_r;
    assign dac_o = dac_r;

    // DAC side
    a_halt_keeps_dac: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (halt_i && !bus_i.we) |=> $stable(dac_r.en))
        else $error("DAC enable moved without a write");
    a_dac_off_silent: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !dac_r.en |-> dac_r.sample == 12'h000)
        else $error("Sample passed while DAC disabled");
    a_dac_enable: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bus_i.we && bus_i.addr == VOICE_CONTROL_OFF)
        |=> dac_o.en == $past(bus_i.wdata[DAC_EN_BIT]))
        else $error("DAC enable does not follow write");
    a_sample_build: assert property (
        @(posedge clk_i) disable iff (rst_i)
        dac_r.en |-> dac_r.sample == {ahigh_r, alow_r})
        else $error("Sample assembly wrong");
    a_vol_level: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bus_i.we && bus_i.addr == VOLUME_OFF)
        |=> dac_o.volume == $past(bus_i.wdata[6:4]))
        else $error("Volume level does not follow write");

    // Register reads and control bits
    a_ctrl_unused_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ctrl_r & ~VOICE_CONTROL_MASK) == 8'h00)
        else $error("Unused control bits set");
    a_ctrl_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bus_i.re && bus_i.addr == VOICE_CONTROL_OFF)
        |=> rdata_o == $past(ctrl_r))
        else $error("Control read back wrong");
    a_xtal_start: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bus_i.we && bus_i.addr == VOICE_CONTROL_OFF)
        |=> xtal_slow_start_o == $past(bus_i.wdata[SLOW_START_BIT]))
        else $error("Crystal start bit does not follow write");
    a_low_nibble_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bus_i.re && (bus_i.addr == AUDIO_LOW_OFF || bus_i.addr == VOLUME_OFF))
        |=> rdata_o[3:0] == 4'h0)
        else $error("Low nibble read nonzero");

    // Fetch sequencing; a fetch cut by disabling the ROM may end early
    a_fetch_latency: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ($fell(rom_busy_o) && ctrl_r[ROM_EN_BIT])
        |-> busy_len_r >= FETCH_CYC_W)
        else $error("Fetch shorter than minimum");
    a_addr_restart: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bus_i.we && ctrl_r[ROM_EN_BIT] && bus_i.addr
            == (ctrl_r[SEL_BIT] ? ADDR1_LOW_OFF : ADDR0_LOW_OFF))
        |=> rom_busy_o && rom_o.req)
        else $error("Address write did not start a fetch");
    a_rom_off_idle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !ctrl_r[ROM_EN_BIT] |-> !rom_o.req)
        else $error("ROM access while disabled");
    a_busy_is_req: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rom_busy_o == rom_o.req)
        else $error("Busy flag and ROM request disagree");
    a_rom_off_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bus_i.re && bus_i.addr == ROM_BYTE_OFF && !ctrl_r[ROM_EN_BIT])
        |=> rdata_o == 8'h00)
        else $error("ROM byte delivered while disabled");
    a_rom_byte_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (bus_i.re && bus_i.addr == ROM_BYTE_OFF && ctrl_r[ROM_EN_BIT])
        |=> rdata_o == $past(romb_r))
        else $error("ROM byte read wrong");
    a_byte_held: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rom_busy_o |=> $stable(romb_r) || !rom_busy_o)
        else $error("Byte changed mid fetch");
    a_high_upper_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (abyte_r[0][7:4] | abyte_r[3][7:4]) == 4'h0)
        else $error("Upper address bits stored");
    a_sel_addr: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rom_o.req && !ctrl_r[SEL_BIT]) |->
        rom_o.addr == {abyte_r[0][3:0], abyte_r[1], abyte_r[2]})
        else $error("Counter 0 address wrong");

    c_fetch_done: cover property (@(posedge clk_i) $fell(rom_busy_o));
    c_sel_one: cover property (@(posedge clk_i) rom_o.req && ctrl_r[SEL_BIT]);
    c_dac_on: cover property (@(posedge clk_i) $rose(dac_r.en));
    c_restart: cover property (@(posedge clk_i) rom_busy_o && addr_wr);
    c_halt_dac: cover property (@(posedge clk_i) halt_i && dac_r.en);
endmodule
`default_nettype wire

// ===== verif/vrdc_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module vrdc_rom_model #(
    parameter int LAT = 90
) (
    input wire logic clk_i,
    input wire vrdc_pkg::vrdc_rom_req_t rom_i,
    output logic [7:0] data_o
);
    import vrdc_pkg::*;
    logic [7:0] junk_r = 8'h00;
    int held_r = 0;
    logic [19:0] last_r = '0;
    always_ff @(posedge clk_i) begin
        junk_r <= junk_r + 8'h67;
        last_r <= rom_i.addr;
        // A new address starts the array's settling time again
        held_r <= (rom_i.req && rom_i.addr == last_r) ? held_r + 1 : 0;
    end
    // Slow array: the byte settles only late in the fetch window
    assign data_o = (rom_i.req && held_r >= LAT) ?
        (rom_i.addr[7:0] ^ rom_i.addr[19:12] ^ 8'h5A) : junk_r;
endmodule
`default_nettype wire

// ===== verif/test_voice_rom_and_dac_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_voice_rom_and_dac_control;
    import vrdc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic halt_i = 1'b0;
    vrdc_bus_t bus_i = '0;
    logic [7:0] rom_data_i, rdata_o, ctl, lo, hi, volume_level, romb;
    vrdc_rom_req_t rom_o;
    vrdc_dac_t dac_o;
    logic xtal_slow_start_o, rom_busy_o;
    logic [7:0] adr [0:1][0:2];
    int n_fail = 0;
    int n_checks = 0;
    int cnt, k;
    always #20 clk_i = ~clk_i;
    vrdc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
        .halt_i(halt_i), .rom_data_i(rom_data_i), .rdata_o(rdata_o),
        .rom_o(rom_o), .dac_o(dac_o), .xtal_slow_start_o(xtal_slow_start_o),
        .rom_busy_o(rom_busy_o));
    vrdc_rom_model ROM (.clk_i(clk_i), .rom_i(rom_o), .data_o(rom_data_i));
    function automatic logic [19:0] cur_addr();
        return {adr[ctl[4]][0][3:0], adr[ctl[4]][1], adr[ctl[4]][2]};
    endfunction
    function automatic logic [7:0] rom_val(input logic [19:0] a);
        return a[7:0] ^ a[19:12] ^ 8'h5A;
    endfunction
    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_i);
        #2;
        halt_i = 1'($urandom);
        bus_i = '{we: 1'b1, re: 1'b0, addr: ad, wdata: d};
        @(posedge clk_i);
        #2;
        bus_i.we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e,
                      input logic [7:0] m);
        @(posedge clk_i);
        #2;
        bus_i = '{we: 1'b0, re: 1'b1, addr: ad, wdata: 8'h00};
        @(posedge clk_i);
        #2;
        bus_i.re = 1'b0;
        chk(20'(rdata_o & m), 20'(e & m));
    endtask
    task automatic drain();
        cnt = 0;
        while (rom_busy_o === 1'b1 && cnt < 1000) begin
            chk(rom_o.addr, cur_addr());
            @(posedge clk_i);
            #2;
            cnt++;
        end
        if (cnt > 0) romb = rom_val(cur_addr());
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(40 * 30000);
        n_fail++;
        finish_test();
    end
    initial begin
        void'($urandom(97279));
        {ctl, lo, hi, volume_level, romb} = '0;
        adr = '{default: 8'h00};
        repeat (12) @(posedge clk_i);
        #2;
        rst_i = 1'b0;
        rd(8'h30, 8'h00, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            ctl = 8'($urandom);
            ctl[2] = i[0];
            ctl[4] = i[1];
            ctl[1] = i[2];
            lo = 8'($urandom);
            hi = 8'($urandom);
            volume_level = {1'($urandom), 3'(i), 4'($urandom)};
            wr(VOICE_CONTROL_OFF, ctl);
            drain();
            wr(AUDIO_LOW_OFF, lo);
            wr(AUDIO_HIGH_OFF, hi);
            wr(VOLUME_OFF, volume_level);
            repeat (2) @(posedge clk_i);
            #2;
            chk(dac_o.en, ctl[1]);
            chk(dac_o.sample, ctl[1] ? {hi, lo[7:4]} : 12'h000);
            chk(dac_o.volume, volume_level[6:4]);
            chk(xtal_slow_start_o, ctl[7]);
            rd(VOICE_CONTROL_OFF, ctl & VOICE_CONTROL_MASK, 8'hFF);
            rd(AUDIO_LOW_OFF, lo & 8'hF0, 8'hFF);
            rd(AUDIO_HIGH_OFF, hi, 8'hFF);
            rd(VOLUME_OFF, volume_level & 8'h70, 8'hFF);
            k = int'(ctl[4]);
            for (int j = 0; j < 3; j++) begin
                adr[k][j] = 8'($urandom);
                wr(ADDR0_HIGH_OFF + 8'(3 * k + j), adr[k][j]);
            end
            if (ctl[2]) begin
                rd(ROM_BYTE_OFF, romb, 8'hFF);
                drain();
                chk(20'(cnt + 2 >= FETCH_CYC), 20'd1);
            end else begin
                chk(rom_o.req, 1'b0);
            end
            rd(ROM_BYTE_OFF, ctl[2] ? romb : 8'h00, 8'hFF);
            adr[1 - k][2] = 8'($urandom);
            wr(ADDR0_LOW_OFF + 8'(3 * (1 - k)), adr[1 - k][2]);
            chk(rom_busy_o, 1'b0);
            rd(ADDR0_HIGH_OFF + 8'(3 * k), adr[k][0] & 8'h0F, 8'hFF);
        end
        finish_test();
    end
endmodule
`default_nettype wire
